// ### logic/swap_skip_pkg.sv
// Purpose: Shared constants and types for the swap and skip-if-zero executor
// Assumes: 8-bit data path, one instruction cycle per sys_clk enable pulse
// Notes: Opcode encodings are local to this block
//
// Summary of operation
// - The nibble swap puts memory bits 7..4 in accumulator bits 3..0 and bits 3..0 in 7..4.
// - The nibble swap writes only the accumulator and never writes data memory.
// - The memory skip-if-zero op reads the byte and writes the same value back.
// - The memory skip-if-zero op skips the next instruction when the byte is zero.
// - A taken skip inserts a dummy instruction so the op takes three instruction cycles.
// - A nonzero tested byte lets the next instruction run normally.
// - The accumulator-load skip-if-zero op loads the byte into the accumulator and skips on zero.
// - A taken skip of the accumulator-load op also takes three instruction cycles.
package swap_skip_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_SWAP = 2'h1;
  localparam logic [1:0] OP_MEM_SKZ = 2'h2;
  localparam logic [1:0] OP_ACC_SKZ = 2'h3;
  localparam int unsigned NIB_HI = 4;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam int unsigned CYCLES_NOSKIP = 2;
  localparam int unsigned CYCLES_SKIP = 3;
  localparam int unsigned CLK_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'h3;

  typedef struct packed {
    logic valid;
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
  } instr_type;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_type;
endpackage : swap_skip_pkg

// ### logic/cycle_enable.sv
// Purpose: Instruction cycle enable divider
// Assumes: sys_clk at 25 MHz
// Notes: One pulse every CLK_DIV clocks
`timescale 1ns/1ps
module cycle_enable (
  input wire logic sys_clk,
  input wire logic srst,
  output logic cyc_en
);
  import swap_skip_pkg::*;
  logic [1:0] cnt_ff;

  // Free running divider
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  assign cyc_en = (cnt_ff == DIV_LAST);
endmodule : cycle_enable

// ### logic/swap_skip_exec.sv
// Purpose: Executes nibble swap, memory skip-if-zero and acc-load skip-if-zero
// Assumes: Memory read data is valid in the cycle after rd_en with cyc_en
// Notes: Status flags are passed through untouched
`timescale 1ns/1ps
module swap_skip_exec (
  input wire logic sys_clk,
  input wire logic srst,
  input wire swap_skip_pkg::instr_type instr,
  input wire logic [swap_skip_pkg::DATA_W-1:0] mem_rdata,
  input wire logic [3:0] flags_in,
  output swap_skip_pkg::mem_req_type mem_req,
  output logic [swap_skip_pkg::DATA_W-1:0] acc_ff,
  output logic [3:0] flags_out,
  output logic instr_ready,
  output logic skip_next,
  output logic dummy_cycle,
  output logic cyc_en
);
  import swap_skip_pkg::*;

  // ----------------------------------------
  // State and divider
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DUMMY = 3'b100
  } state_type;

  state_type state_ff;
  state_type nxt_state;
  logic [1:0] op_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic is_zero;
  logic skip_op;

  cycle_enable u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .cyc_en(cyc_en)
  );

  // Zero test shared by both skip ops
  function automatic logic byte_zero(input logic [DATA_W-1:0] b);
    byte_zero = (b == ZERO_BYTE);
  endfunction : byte_zero

  assign is_zero = byte_zero(mem_rdata);
  assign skip_op = (op_ff == OP_MEM_SKZ) || (op_ff == OP_ACC_SKZ);
  assign instr_ready = (state_ff == ST_IDLE);
  assign dummy_cycle = (state_ff == ST_DUMMY);

  // Flags never touched
  assign flags_out = flags_in;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (instr.valid && instr.op != OP_NONE) begin
          nxt_state = ST_EXEC;
        end
      end
      // Both skip ops decide in the exec slot; only the memory op writes back, in the next slot
      ST_EXEC: begin
        if (skip_op && is_zero) begin
          nxt_state = ST_DUMMY;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DUMMY: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
    end else if (cyc_en) begin
      state_ff <= nxt_state;
    end
  end

  // Latch the instruction
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      op_ff <= OP_NONE;
      addr_ff <= '0;
    end else if (cyc_en && state_ff == ST_IDLE && instr.valid) begin
      op_ff <= instr.op;
      addr_ff <= instr.addr;
    end
  end

  // ----------------------------------------
  // Memory port
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem_req <= '0;
    end else if (cyc_en) begin
      mem_req.rd_en <= (nxt_state == ST_EXEC);
      mem_req.addr <= (state_ff == ST_IDLE) ? instr.addr : addr_ff;
      // Write back the value read, swap never writes
      mem_req.wr_en <= (state_ff == ST_EXEC) && (op_ff == OP_MEM_SKZ);
      mem_req.wdata <= mem_rdata;
    end
  end

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_ff <= ACC_RESET;
    end else if (cyc_en && state_ff == ST_EXEC) begin
      if (op_ff == OP_SWAP) begin
        acc_ff <= {mem_rdata[NIB_HI-1:0], mem_rdata[DATA_W-1:NIB_HI]};
      end else if (op_ff == OP_ACC_SKZ) begin
        acc_ff <= mem_rdata;
      end
    end
  end

  // Skip request toward fetch, one instruction cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      skip_next <= 1'b0;
    end else if (cyc_en) begin
      skip_next <= (nxt_state == ST_DUMMY);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Dummy slot lasts one instruction cycle of CLK_DIV clocks, then idle
  sequence s_dummy_slot;
    state_ff == ST_DUMMY [*4] ##1 state_ff == ST_IDLE;
  endsequence : s_dummy_slot

  // Skip request stands one instruction cycle
  sequence s_skip_strobe;
    skip_next [*4] ##1 !skip_next;
  endsequence : s_skip_strobe

  // Write-back strobe stands one instruction cycle
  sequence s_wb_strobe;
    mem_req.wr_en [*4] ##1 !mem_req.wr_en;
  endsequence : s_wb_strobe

  a_swap_nibbles: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_SWAP
    |=> acc_ff == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("swap result wrong");
  a_swap_nowrite: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == ST_EXEC && op_ff == OP_SWAP |=> !mem_req.wr_en)
    else $error("swap wrote memory");
  a_wb_same: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_MEM_SKZ
    |=> mem_req.wr_en && mem_req.wdata == $past(mem_rdata) && mem_req.addr == addr_ff)
    else $error("write back wrong");
  a_mem_skip: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_MEM_SKZ && is_zero
    |=> skip_next && state_ff == ST_DUMMY)
    else $error("zero did not skip");
  a_dummy_len: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_DUMMY |=> state_ff == ST_IDLE)
    else $error("dummy cycle length wrong");
  a_no_skip: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && skip_op && !is_zero
    |=> !skip_next && state_ff == ST_IDLE)
    else $error("nonzero skipped");
  a_acc_load: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_ACC_SKZ
    |=> acc_ff == $past(mem_rdata) && skip_next == $past(is_zero))
    else $error("acc load skip wrong");
  a_acc_three: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_ACC_SKZ && is_zero
    |=> s_dummy_slot)
    else $error("acc skip not three cycles");
  a_flags_kept: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff != ST_IDLE |-> flags_out == flags_in)
    else $error("flags changed");

  // ----------------------------------------
  // Slot and strobe checks
  // ----------------------------------------
  // Memory skip op on a zero byte ends with one dummy slot
  a_mem_three: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_MEM_SKZ && is_zero
    |=> s_dummy_slot)
    else $error("mem skip not three cycles");
  // Skip request is one instruction cycle wide
  a_skip_width: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(skip_next) |-> s_skip_strobe)
    else $error("skip request width wrong");
  // Write-back is a single strobe
  a_wb_single: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(mem_req.wr_en) |-> s_wb_strobe)
    else $error("write back width wrong");
  // Write-back goes to the latched address
  a_wb_addr: assert property (@(posedge sys_clk) disable iff (srst)
    mem_req.wr_en |-> mem_req.addr == addr_ff)
    else $error("write back address wrong");
  // Read issued for the byte named by a taken instruction
  a_read_issue: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && instr_ready && instr.valid && instr.op != OP_NONE
    |=> mem_req.rd_en && mem_req.addr == $past(instr.addr))
    else $error("read not issued");
  // Swap only loads the accumulator, never skips
  a_swap_noskip: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && op_ff == OP_SWAP
    |=> !skip_next && state_ff == ST_IDLE)
    else $error("swap skipped");
  // Nonzero byte leaves no dummy slot
  a_no_dummy: assert property (@(posedge sys_clk) disable iff (srst)
    cyc_en && state_ff == ST_EXEC && skip_op && !is_zero
    |=> !dummy_cycle [*4])
    else $error("dummy slot on nonzero");
endmodule : swap_skip_exec

// ### test/tb_nibble_swap_and_skip_if_zero_ops.sv
// Purpose: Self-checking bench for the swap and skip-if-zero executor
// Assumes: Inputs change at the falling edge; read data is held for the whole operation
// Notes: A decoy swap is presented while busy and must be ignored
`timescale 1ns/1ps
module tb_nibble_swap_and_skip_if_zero_ops;
  import swap_skip_pkg::*;
  logic sys_clk, srst, instr_ready, skip_next, dummy_cycle, cyc_en;
  logic seen_wr, seen_skip, seen_dummy, wr_ok, rd_ok;
  instr_type instr;
  mem_req_type mem_req;
  logic [DATA_W-1:0] mem_rdata, acc_ff;
  logic [3:0] flags_in, flags_out;
  int error_cnt = 0;
  int n_checks = 0;
  int n_cyc = 0;

  swap_skip_exec DUT (.sys_clk(sys_clk), .srst(srst), .instr(instr), .mem_rdata(mem_rdata),
    .flags_in(flags_in), .mem_req(mem_req), .acc_ff(acc_ff), .flags_out(flags_out),
    .instr_ready(instr_ready), .skip_next(skip_next), .dummy_cycle(dummy_cycle),
    .cyc_en(cyc_en));

  // ----------------------------------------
  // Clock, report and compare helpers
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  // Issue one op, record memory traffic and skip signals until idle again
  task automatic exec(input logic [1:0] op, input logic [7:0] d, input logic [3:0] fl);
    int n;
    logic [7:0] a;
    logic done;
    n = 0;
    done = 1'b0;
    n_cyc = 0;
    a = {6'h2a, op};
    {seen_wr, seen_skip, seen_dummy, rd_ok} = 4'h0;
    wr_ok = 1'b1;
    mem_rdata = d;
    flags_in = fl;
    instr = '{valid: 1'b1, op: op, addr: a};
    while (instr_ready !== 1'b0) begin
      @(negedge sys_clk);
      n++;
      if (n > 40) begin
        $display("BAD take timeout expected %0d seen %0d", 40, n);
        error_cnt++;
        conclude();
      end
    end
    instr = '{valid: 1'b1, op: OP_SWAP, addr: ~a}; // Decoy while busy
    while (!done) begin
      chk("flags_out", {4'h0, fl}, {4'h0, flags_out});
      if (mem_req.rd_en === 1'b1 && mem_req.addr === a) rd_ok = 1'b1;
      if (mem_req.wr_en === 1'b1) begin
        seen_wr = 1'b1;
        wr_ok = (mem_req.addr === a) && (mem_req.wdata === d);
      end
      if (skip_next === 1'b1) seen_skip = 1'b1;
      if (dummy_cycle === 1'b1) seen_dummy = 1'b1;
      done = (instr_ready === 1'b1);
      if (!done) begin
        if (cyc_en === 1'b1) n_cyc++;
        @(negedge sys_clk);
        n++;
        if (n > 100) begin
          $display("BAD done timeout expected %0d seen %0d", 100, n);
          error_cnt++;
          conclude();
        end
      end
    end
    instr.valid = 1'b0;
    mem_rdata = ~d;
    repeat (CLK_DIV) @(negedge sys_clk);
  endtask : exec

  // Judge accumulator, write/skip/dummy events and read/write-back addressing
  task automatic judge(input string name, input logic [7:0] acc_exp, input logic [2:0] evt);
    chk({name, " acc"}, acc_exp, acc_ff);
    chk({name, " wr skip dummy"}, {5'h0, evt}, {5'h0, seen_wr, seen_skip, seen_dummy});
    chk({name, " read addr"}, 8'h01, {7'h0, rd_ok});
    chk({name, " write back"}, 8'h01, {7'h0, wr_ok});
    chk({name, " cycles"}, evt[1] ? 8'(CYCLES_SKIP) : 8'(CYCLES_NOSKIP), 8'(n_cyc + 1));
    $display("test %s done", name);
  endtask : judge

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_swap_zero;
    exec(OP_SWAP, 8'h00, 4'hf);
    judge("swap zero", 8'h00, 3'b000);
  endtask : test_swap_zero

  task automatic test_swap;
    exec(OP_SWAP, 8'h3c, 4'ha);
    judge("swap", 8'hc3, 3'b000);
  endtask : test_swap

  task automatic test_mem_zero;
    exec(OP_MEM_SKZ, 8'h00, 4'h5);
    judge("mem zero", 8'hc3, 3'b111);
  endtask : test_mem_zero

  task automatic test_mem_nonzero;
    exec(OP_MEM_SKZ, 8'h81, 4'h0);
    judge("mem nonzero", 8'hc3, 3'b100);
  endtask : test_mem_nonzero

  task automatic test_acc_nonzero;
    exec(OP_ACC_SKZ, 8'h7e, 4'h3);
    judge("acc nonzero", 8'h7e, 3'b000);
  endtask : test_acc_nonzero

  task automatic test_acc_zero;
    exec(OP_ACC_SKZ, 8'h00, 4'h9);
    judge("acc zero", 8'h00, 3'b011);
  endtask : test_acc_zero

  // Main sequence
  initial begin
    srst = 1'b1;
    instr = '0;
    mem_rdata = 8'h00;
    flags_in = 4'h0;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    test_swap_zero();
    test_swap();
    test_mem_zero();
    test_mem_nonzero();
    test_acc_nonzero();
    test_acc_zero();
    conclude();
  end
endmodule : tb_nibble_swap_and_skip_if_zero_ops
